// *** hw/eeac_ctrl.sv ***
// nonvolatile byte store with index, value and control registers
//
// Overview of operation
// RULE1: 128 bytes addressed by 7-bit index
// RULE2: index bit 7 always reads zero
// RULE3: software loads index before any access
// RULE4: value register feeds writes, receives reads
// RULE5: read stalls four cycles, program two
// RULE6: mode selects atomic, erase, write, reserved
// RULE7: mode writes ignored while busy
// RULE8: reset clears mode unless programming; the code clears it once programming ends
// RULE9: ready interrupt level while enabled and idle
// RULE10: arm bit self-clears four cycles later
// RULE11: go needs arm within four cycles
// RULE12: accepted go starts mode at index
// RULE13: go bit busy until programming time ends
// RULE14: read strobe loads value register immediately
// RULE15: busy refuses reads and index writes
// RULE16: programming survives system reset
// RULE17: duration counted with parameter terminal counts
// RULE18: go with reserved mode does nothing
`timescale 1ns/10ps
`default_nettype none
`include "eeac_defines.svh"
module eeac_ctrl
    import eeac_pkg::*;
#(
    parameter logic [15:0] ATOMIC_CYCLES = 16'(`EEAC_ATOMIC_CYCLES),
    parameter logic [15:0] SPLIT_CYCLES = 16'(`EEAC_SPLIT_CYCLES)
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic por_n,
    input wire logic ce,
    input wire logic [1:0] io_sel,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic global_irq_enable,
    output logic ready_irq,
    output logic cpu_stall
);
    // storage and programming engine live on the power-on reset only,
    // so a system reset cannot abort a running operation
    logic [7:0] cells [`EEAC_DEPTH];
    eeac_state_type state, next_state;
    logic [15:0] timer, next_timer;
    eeac_mode_type mode, next_mode, op_mode, next_op_mode;
    logic [6:0] op_index, next_op_index;
    logic [7:0] op_value, next_op_value;
    logic sys_rst_seen, next_sys_rst_seen;
    // software-facing state, on system reset except the index, which has no reset
    logic [6:0] nv_byte_index, next_nv_byte_index;
    logic [7:0] nv_byte_value, next_nv_byte_value;
    logic ready_irq_enable, next_ready_irq_enable;
    logic [2:0] arm_cnt, next_arm_cnt;
    logic [2:0] stall_cnt, next_stall_cnt;
    logic [7:0] next_io_rdata;
    logic busy, wr_index, wr_value, wr_ctrl, go_ok, read_ok, commit;

    function automatic logic [7:0] control_image(
        input eeac_mode_type m, input logic rie, input logic arm,
        input logic bsy);
        control_image = 8'h00;
        control_image[`EEAC_BIT_MODE_HIGH:`EEAC_BIT_MODE_LOW] = m;
        control_image[`EEAC_BIT_RIE] = rie;
        control_image[`EEAC_BIT_ARM] = arm;
        control_image[`EEAC_BIT_GO] = bsy;
    endfunction

    assign busy = (state == eeac_busy);
    assign wr_index = io_wr && io_sel == `EEAC_SEL_INDEX;
    assign wr_value = io_wr && io_sel == `EEAC_SEL_VALUE;
    assign wr_ctrl = io_wr && io_sel == `EEAC_SEL_CONTROL;
    assign go_ok = wr_ctrl && io_wdata[`EEAC_BIT_GO] && arm_cnt != 3'h0
        && !busy && mode != eeac_reserved; // RULE11 RULE18
    assign read_ok = wr_ctrl && io_wdata[`EEAC_BIT_READ] && !busy; // RULE15
    assign commit = busy && timer == 16'h0001;
    assign cpu_stall = stall_cnt != 3'h0; // RULE5
    assign ready_irq = ready_irq_enable && global_irq_enable && !busy; // RULE9

    // engine
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_op_mode = op_mode;
        next_op_index = op_index;
        next_op_value = op_value;
        next_mode = mode;
        // flag held until the engine is idle, else a busy reset is lost
        next_sys_rst_seen = sys_rst_seen && busy; // RULE8
        if (wr_ctrl && !busy) begin
            next_mode = eeac_mode_type'(
                io_wdata[`EEAC_BIT_MODE_HIGH:`EEAC_BIT_MODE_LOW]); // RULE7
        end
        if (sys_rst_seen && !busy) begin
            next_mode = eeac_atomic; // RULE8
        end
        case (state)
            eeac_idle: begin
                if (go_ok) begin
                    next_state = eeac_busy; // RULE12
                    next_op_mode = mode;
                    next_op_index = nv_byte_index;
                    next_op_value = nv_byte_value;
                    next_timer = (mode == eeac_atomic) ?
                        ATOMIC_CYCLES : SPLIT_CYCLES; // RULE6 RULE17
                end
            end
            eeac_busy: begin
                next_timer = timer - 16'h0001; // RULE17
                if (commit) begin
                    next_state = eeac_idle; // RULE13
                end
            end
            default: next_state = eeac_idle;
        endcase
    end

    always_ff @(posedge clock or negedge por_n) begin
        if (!por_n) begin
            state <= eeac_idle;
            timer <= 16'h0000;
            op_mode <= eeac_atomic;
            op_index <= 7'h00;
            op_value <= 8'h00;
            mode <= eeac_atomic;
        end else if (ce) begin
            state <= next_state; // RULE16
            timer <= next_timer;
            op_mode <= next_op_mode;
            op_index <= next_op_index;
            op_value <= next_op_value;
            mode <= next_mode;
        end
    end

    // reset seen as a level, so mode clears once the engine is idle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sys_rst_seen <= 1'b1;
        end else if (ce) begin
            sys_rst_seen <= next_sys_rst_seen;
        end
    end

    // write-only can only clear bits, hence the and with old contents
    always_ff @(posedge clock) begin
        if (ce && commit) begin
            case (op_mode)
                eeac_atomic: cells[op_index] <= op_value; // RULE6
                eeac_erase_only: cells[op_index] <= `EEAC_ERASED;
                eeac_write_only: cells[op_index] <= cells[op_index] & op_value;
                default: cells[op_index] <= cells[op_index];
            endcase
        end
    end

    // software registers
    always_comb begin
        next_nv_byte_index = nv_byte_index;
        next_nv_byte_value = nv_byte_value;
        next_ready_irq_enable = ready_irq_enable;
        next_arm_cnt = (arm_cnt != 3'h0) ? arm_cnt - 3'h1 : 3'h0;
        next_stall_cnt = (stall_cnt != 3'h0) ? stall_cnt - 3'h1 : 3'h0;
        next_io_rdata = io_rdata;
        if (wr_index && !busy) begin
            next_nv_byte_index = io_wdata[6:0]; // RULE1 RULE15
        end
        if (wr_value) begin
            next_nv_byte_value = io_wdata; // RULE4
        end
        if (wr_ctrl) begin
            next_ready_irq_enable = io_wdata[`EEAC_BIT_RIE];
            if (io_wdata[`EEAC_BIT_ARM]) begin
                next_arm_cnt = `EEAC_ARM_CYCLES; // RULE10
            end
        end
        if (read_ok) begin
            next_nv_byte_value = cells[nv_byte_index]; // RULE14
            next_stall_cnt = `EEAC_READ_STALL; // RULE5
        end else if (go_ok) begin
            next_stall_cnt = `EEAC_PROG_STALL; // RULE5
        end
        if (io_rd) begin
            case (io_sel)
                `EEAC_SEL_INDEX: next_io_rdata = {1'b0, nv_byte_index}; // RULE2
                `EEAC_SEL_VALUE: next_io_rdata = nv_byte_value;
                `EEAC_SEL_CONTROL: next_io_rdata = control_image(mode,
                    ready_irq_enable, arm_cnt != 3'h0, busy); // RULE13
                default: next_io_rdata = 8'h00;
            endcase
        end
    end

    // index is left unreset: software must load it first
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            nv_byte_value <= 8'h00;
            ready_irq_enable <= 1'b0;
            arm_cnt <= 3'h0;
            stall_cnt <= 3'h0;
            io_rdata <= 8'h00;
        end else if (ce) begin
            nv_byte_value <= next_nv_byte_value;
            ready_irq_enable <= next_ready_irq_enable;
            arm_cnt <= next_arm_cnt;
            stall_cnt <= next_stall_cnt;
            io_rdata <= next_io_rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (ce) begin
            nv_byte_index <= next_nv_byte_index; // RULE3
        end
    end

    sequence s_arm_write;
        wr_ctrl && io_wdata[`EEAC_BIT_ARM];
    endsequence

    sequence s_arm_window;
        arm_cnt != 3'h0 [*4] ##1 arm_cnt == 3'h0;
    endsequence

    property p_arm_clear;
        @(posedge clock) disable iff (!arst_n || !ce)
        s_arm_write |=> s_arm_window;
    endproperty
    a_arm_clear: assert property (p_arm_clear) // RULE10
        else $error("arm bit not cleared after four cycles");

    property p_go_refused;
        @(posedge clock) disable iff (!arst_n || !por_n || !ce)
        (wr_ctrl && io_wdata[`EEAC_BIT_GO] && !busy
            && (arm_cnt == 3'h0 || mode == eeac_reserved)) |=> !busy;
    endproperty
    a_go_refused: assert property (p_go_refused) // RULE11
        else $error("go accepted without arm or with reserved mode");

    property p_go_start;
        @(posedge clock) disable iff (!por_n || !ce)
        go_ok |=> busy && op_index == $past(nv_byte_index)
            && op_value == $past(nv_byte_value);
    endproperty
    a_go_start: assert property (p_go_start) // RULE12
        else $error("accepted go did not start the operation");

    property p_read_stall;
        @(posedge clock) disable iff (!arst_n || !ce)
        read_ok |=> cpu_stall [*4] ##1 !cpu_stall;
    endproperty
    a_read_stall: assert property (p_read_stall) // RULE5
        else $error("read stall is not four cycles");

    property p_prog_stall;
        @(posedge clock) disable iff (!arst_n || !ce)
        go_ok |=> cpu_stall [*2] ##1 !cpu_stall;
    endproperty
    a_prog_stall: assert property (p_prog_stall) // RULE5
        else $error("program stall is not two cycles");

    property p_read_data;
        @(posedge clock) disable iff (!arst_n || !ce)
        read_ok |=> nv_byte_value == $past(cells[nv_byte_index]);
    endproperty
    a_read_data: assert property (p_read_data) // RULE14
        else $error("read strobe did not load the value register");

    property p_mode_hold;
        @(posedge clock) disable iff (!por_n || !ce)
        busy |=> mode == $past(mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) // RULE7
        else $error("mode changed while busy");

    property p_index_hold;
        @(posedge clock) disable iff (!ce)
        busy |=> nv_byte_index == $past(nv_byte_index);
    endproperty
    a_index_hold: assert property (p_index_hold) // RULE15
        else $error("index changed while busy");

    property p_busy_end;
        @(posedge clock) disable iff (!por_n || !ce)
        $fell(busy) |-> $past(timer) == 16'h0001;
    endproperty
    a_busy_end: assert property (p_busy_end) // RULE13
        else $error("busy dropped before the programming time");

    property p_irq_level;
        @(posedge clock) disable iff (!arst_n || !por_n)
        ready_irq == (ready_irq_enable && global_irq_enable && !busy);
    endproperty
    a_irq_level: assert property (p_irq_level) // RULE9
        else $error("ready interrupt level wrong");
endmodule // eeac_ctrl
`default_nettype wire

// *** hw/eeac_defines.svh ***
// offsets, field positions, erased value and timing counts of the controller
`ifndef EEAC_DEFINES_SVH
`define EEAC_DEFINES_SVH
`define EEAC_SEL_INDEX 2'h0
`define EEAC_SEL_VALUE 2'h1
`define EEAC_SEL_CONTROL 2'h2
`define EEAC_BIT_MODE_HIGH 5
`define EEAC_BIT_MODE_LOW 4
`define EEAC_BIT_RIE 3
`define EEAC_BIT_ARM 2
`define EEAC_BIT_GO 1
`define EEAC_BIT_READ 0
`define EEAC_INDEX_BITS 7
`define EEAC_DEPTH 128
`define EEAC_ERASED 8'hFF
`define EEAC_ARM_CYCLES 3'h4
`define EEAC_READ_STALL 3'h4
`define EEAC_PROG_STALL 3'h2
`define EEAC_CLOCK_HZ 64'd10000000
`define EEAC_ATOMIC_US 64'd3400
`define EEAC_SPLIT_US 64'd1800
`define EEAC_ATOMIC_CYCLES (`EEAC_ATOMIC_US * `EEAC_CLOCK_HZ / 64'd1000000)
`define EEAC_SPLIT_CYCLES (`EEAC_SPLIT_US * `EEAC_CLOCK_HZ / 64'd1000000)
`endif

// *** hw/eeac_pkg.sv ***
// types of the nonvolatile access controller
package eeac_pkg;
    typedef enum logic [1:0] {
        eeac_atomic, eeac_erase_only, eeac_write_only, eeac_reserved
    } eeac_mode_type;
    typedef enum logic {eeac_idle, eeac_busy} eeac_state_type;
endpackage

// *** tb/eeac_core_model.sv ***
// cpu core model issuing register accesses to the controller
`timescale 1ns/10ps
`default_nettype none
module eeac_core_model (
    input wire logic clock,
    input wire logic cpu_stall,
    input wire logic [7:0] io_rdata,
    output logic [1:0] io_sel,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    int hang_count = 0;
    initial begin
        io_sel = 2'h3;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // strobes stay up between back-to-back accesses; quiet drops them
    task automatic quiet();
        if (io_wr || io_rd) begin
            io_wr = 1'b0;
            io_rd = 1'b0;
            io_sel = 2'h3;
        end
    endtask
    // a halted core issues nothing
    task automatic halt_wait();
        int n;
        n = 0;
        if (cpu_stall !== 1'b0) begin
            quiet();
        end
        while (cpu_stall !== 1'b0 && n < 16) begin
            @(negedge clock);
            n++;
        end
        if (n == 16) hang_count++;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        halt_wait();
        io_sel = sel;
        io_wdata = d;
        io_rd = 1'b0;
        io_wr = 1'b1;
        @(negedge clock);
    endtask
    task automatic rd(input logic [1:0] sel, output logic [7:0] d);
        halt_wait();
        io_sel = sel;
        io_wr = 1'b0;
        io_rd = 1'b1;
        @(negedge clock);
        d = io_rdata;
    endtask
    // arm then go back to back, well inside the window
    task automatic start(input logic [7:0] c);
        wr(2'h2, c | 8'h04);
        wr(2'h2, c | 8'h02);
    endtask
    task automatic fetch(input logic [6:0] idx, output logic [7:0] d);
        wr(2'h0, {1'b0, idx});
        wr(2'h2, 8'h01);
        rd(2'h1, d);
    endtask
endmodule // eeac_core_model
`default_nettype wire

// *** tb/eeac_ctrl_tb.sv ***
// self-checking bench of the nonvolatile access controller
`timescale 1ns/10ps
`default_nettype none
module eeac_ctrl_tb;
    import eeac_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic por_n = 1'b0;
    logic ce = 1'b1;
    logic gie = 1'b1;
    logic [1:0] io_sel;
    logic io_wr, io_rd, ready_irq, cpu_stall;
    logic [7:0] io_wdata, io_rdata, v;
    int err_total = 0;
    int total_checks = 0;
    int s, c, n;
    logic [7:0] dat [4] = '{8'h5A, 8'h00, 8'h3C, 8'h11};
    logic [7:0] exp [4] = '{8'h5A, 8'hFF, 8'h3C, 8'h3C};
    logic [7:0] dur [4] = '{8'h14, 8'h0A, 8'h0A, 8'h00};
    always #50 clock = ~clock;
    // short programming counts keep the run brief
    eeac_ctrl #(.ATOMIC_CYCLES(16'h0014), .SPLIT_CYCLES(16'h000A)) uut (
        .clock(clock), .arst_n(arst_n), .por_n(por_n), .ce(ce),
        .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_irq_enable(gie), .ready_irq(ready_irq),
        .cpu_stall(cpu_stall));
    eeac_core_model core (
        .clock(clock), .cpu_stall(cpu_stall), .io_rdata(io_rdata),
        .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata));
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        if (core.hang_count != 0) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic stall_len(output int k);
        k = 0;
        if (cpu_stall === 1'b1) begin
            core.quiet();
        end
        while (cpu_stall === 1'b1 && k < 8) begin
            @(negedge clock);
            k++;
        end
    endtask
    // busy shows as the ready level held low
    task automatic busy_len(output int k);
        k = 0;
        if (ready_irq !== 1'b1) begin
            core.quiet();
        end
        while (ready_irq !== 1'b1 && k < 100) begin
            @(negedge clock);
            k++;
        end
        if (k == 100) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    initial begin
        repeat (10) @(negedge clock);
        por_n = 1'b1;
        arst_n = 1'b1;
        core.rd(2'h2, v);
        chk(v, 8'h00);
        core.rd(2'h3, v);
        chk(v, 8'h00);
        core.wr(2'h0, 8'hFF);
        core.rd(2'h0, v);
        chk(v, 8'h7F);
        // every mode code on the top cell, reserved last
        for (int i = 0; i < 4; i++) begin
            core.wr(2'h0, 8'h7F);
            core.wr(2'h1, dat[i]);
            core.start({2'b00, 2'(i), 4'h8});
            stall_len(s);
            chk(8'(s), (i == 3) ? 8'h00 : 8'h02);
            busy_len(c);
            chk(8'(s + c), dur[i]);
            core.fetch(7'h7F, v);
            chk(v, exp[i]);
        end
        core.wr(2'h0, 8'h7F);
        core.wr(2'h2, 8'h01);
        // clock enable low freezes the stall count
        core.quiet();
        ce = 1'b0;
        repeat (3) @(negedge clock);
        ce = 1'b1;
        stall_len(s);
        chk(8'(s), 8'h04);
        core.rd(2'h1, v);
        chk(v, 8'h3C);
        // accesses refused while cell 0 programs
        core.wr(2'h0, 8'h00);
        core.wr(2'h1, 8'h66);
        core.start(8'h08);
        core.wr(2'h0, 8'h10);
        core.wr(2'h2, 8'h39);
        core.rd(2'h2, v);
        chk(v, 8'h0A);
        chk({7'h00, ready_irq}, 8'h00);
        core.rd(2'h0, v);
        chk(v, 8'h00);
        core.rd(2'h1, v);
        chk(v, 8'h66);
        busy_len(c);
        gie = 1'b0;
        @(negedge clock);
        chk({7'h00, ready_irq}, 8'h00);
        gie = 1'b1;
        core.fetch(7'h00, v);
        chk(v, 8'h66);
        // arm expires, late go does nothing
        core.wr(2'h2, 8'h0C);
        core.rd(2'h2, v);
        chk(v, 8'h0C);
        core.quiet();
        repeat (4) @(negedge clock);
        core.rd(2'h2, v);
        chk(v, 8'h08);
        core.wr(2'h2, 8'h0A);
        chk({7'h00, ready_irq}, 8'h01);
        // system reset in mid erase must not abort it
        core.wr(2'h0, 8'h7F);
        core.start(8'h10);
        core.quiet();
        repeat (3) @(negedge clock);
        arst_n = 1'b0;
        @(negedge clock);
        arst_n = 1'b1;
        core.rd(2'h2, v);
        chk(v, 8'h12);
        n = 0;
        do begin
            core.rd(2'h2, v);
            n++;
        end while (v[1] !== 1'b0 && n < 40);
        if (n == 40) begin
            err_total++;
            tally_and_finish();
        end
        core.rd(2'h2, v);
        chk(v, 8'h00);
        core.fetch(7'h7F, v);
        chk(v, 8'hFF);
        tally_and_finish();
    end
endmodule // eeac_ctrl_tb
`default_nettype wire
